// ==== hdl/param_editor.sv ====
`timescale 1ns/10ps
`include "editor_map.svh"
// Function
// [RULE1] Set on a decimal parameter shows its low five digits with the rightmost point lit.
// [RULE2] Mode toggles a decimal value between the low screen and the high two-digit screen.
// [RULE3] Set on a decimal value screen enters edit with the lowest shown digit flashing.
// [RULE4] In decimal edit each mode press moves the flashing digit one place left; the code holds it once it reaches the minus position.
// [RULE5] In edit each up press raises only the flashing digit by one.
// [RULE6] In decimal edit a set press, and in hex edit a mode press, commits the pending value and leaves edit.
// [RULE7] On the signed high screen the top position shows a minus and set stores a negative.
// [RULE8] A negative decimal value on its low screen lights the two leftmost points.
// [RULE9] Outside edit, up on a value screen advances to the next parameter number.
// [RULE10] A hex parameter first shows its low four digits with the leftmost bottom segment lit.
// [RULE11] Mode toggles a hex value between the low word and the high word with the top segment.
// [RULE12] In hex edit each set press moves the flashing digit one place left; on the top digit the code commits and leaves edit instead.
// [RULE13] In edit each down press lowers the flashing digit and the display follows at once.
// [RULE14] Parameters that take effect at power-up keep their applied value until then.
// [RULE15] Digit steps wrap inside zero to nine or zero to fifteen without any carry.
module param_editor #(
   parameter int BLINK_CYCLES = `ED_BLINK_CYCLES,
   parameter logic [7:0] POWERUP_MASK = 8'h01
) (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic KEY_SET,
   input wire logic KEY_MODE,
   input wire logic KEY_UP,
   input wire logic KEY_DOWN,
   output logic [2:0] PARAM_INDEX,
   output logic [31:0] PARAM_APPLIED,
   output logic [4:0] DIGIT_CODE [5],
   output logic [4:0] POINT_ON,
   output logic SEG_TOP_MARK,
   output logic SEG_BOTTOM_MARK
);
   // Digits are stored as magnitude nibbles plus a sign; hex uses all eight nibbles.
   logic [31:0] stored_r [8];
   logic stored_neg_r [8];
   logic [31:0] applied_r [8];
   logic [31:0] pend_r;
   logic pend_neg_r;
   logic [2:0] index_r;
   logic high_r;
   logic [2:0] pos_r;
   editor_pkg::state_t state_r;
   logic [3:0] press;
   logic blink;
   logic is_hex;
   logic [3:0] sel_digit;
   logic [3:0] max_digit;
   logic [31:0] view_val;
   logic view_neg;
   logic minus_sel;

   key_pulse u_keys (
      .MCLK(MCLK),
      .RSTN(RSTN),
      .KEY_LEVEL({KEY_DOWN, KEY_UP, KEY_MODE, KEY_SET}),
      .KEY_PRESS(press)
   );

   blink_timer #(.BLINK_CYCLES(BLINK_CYCLES)) u_blink (
      .MCLK(MCLK),
      .RSTN(RSTN),
      .BLINK_PHASE(blink)
   );

   // Upper half of the parameter numbers are hexadecimal.
   assign is_hex = (index_r >= `ED_PARAM_HEX_FIRST);
   assign sel_digit = pend_r[{pos_r, 2'b00} +: 4];
   assign max_digit = is_hex ? 4'hf : 4'h9; // [RULE15]
   // The minus position only exists on a decimal value's top digit.
   assign minus_sel = !is_hex && (pos_r == `ED_DEC_TOP_POS);
   assign view_val = (state_r == editor_pkg::ST_EDIT) ? pend_r : stored_r[index_r];
   assign view_neg = (state_r == editor_pkg::ST_EDIT) ? pend_neg_r : stored_neg_r[index_r];

   // Screen and parameter navigation, and the edit state machine.
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         state_r <= editor_pkg::ST_NUMBER;
         index_r <= 3'h0;
         high_r <= 1'b0;
         pos_r <= 3'h0;
      end else begin
         unique case (state_r)
            editor_pkg::ST_NUMBER: begin
               if (press[0]) begin
                  state_r <= editor_pkg::ST_VIEW; // [RULE1] [RULE10]
                  high_r <= 1'b0;
               end else if (press[2]) begin
                  index_r <= index_r + 3'h1;
               end else if (press[3]) begin
                  index_r <= index_r - 3'h1;
               end
            end
            editor_pkg::ST_VIEW: begin
               if (press[1]) begin
                  high_r <= ~high_r; // [RULE2] [RULE11]
               end else if (press[0]) begin
                  state_r <= editor_pkg::ST_EDIT; // [RULE3]
                  // Edit starts on the lowest digit of the screen that is shown.
                  if (!high_r) begin
                     pos_r <= 3'h0;
                  end else if (is_hex) begin
                     pos_r <= `ED_HEX_WORD_DIGITS;
                  end else begin
                     pos_r <= `ED_DEC_LOW_DIGITS;
                  end
               end else if (press[2]) begin
                  index_r <= index_r + 3'h1; // [RULE9]
                  high_r <= 1'b0;
               end
            end
            editor_pkg::ST_EDIT: begin
               if (is_hex && press[0]) begin
                  // Set walks left in hex; at the top digit it stores the value and leaves edit.
                  if (pos_r == `ED_HEX_TOP_POS) begin
                     state_r <= editor_pkg::ST_VIEW;
                  end else begin
                     pos_r <= pos_r + 3'h1; // [RULE12]
                  end
                  high_r <= (pos_r + 3'h1) >= `ED_HEX_WORD_DIGITS;
               end else if (is_hex && press[1]) begin
                  state_r <= editor_pkg::ST_VIEW; // [RULE6]
               end else if (!is_hex && press[1]) begin
                  // Selection stops at the minus position.
                  if (pos_r != `ED_DEC_TOP_POS) begin
                     pos_r <= pos_r + 3'h1; // [RULE4]
                  end
                  high_r <= (pos_r + 3'h1) >= `ED_DEC_LOW_DIGITS;
               end else if (!is_hex && press[0]) begin
                  state_r <= editor_pkg::ST_VIEW; // [RULE6]
               end
            end
            default: begin
               state_r <= editor_pkg::ST_NUMBER;
            end
         endcase
      end
   end

   // Pending value: loaded on entry to edit, stepped one digit at a time.
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         pend_r <= `ED_RESET_VALUE;
         pend_neg_r <= 1'b0;
      end else if (state_r == editor_pkg::ST_VIEW && press[0]) begin
         pend_r <= stored_r[index_r];
         pend_neg_r <= stored_neg_r[index_r];
      end else if (state_r == editor_pkg::ST_EDIT && !is_hex && press[1] &&
         pos_r == `ED_DEC_LOW_DIGITS) begin
         // Stepping onto the minus position turns the sign on once, so down can clear it later.
         pend_neg_r <= 1'b1; // [RULE7]
      end else if (state_r == editor_pkg::ST_EDIT && minus_sel) begin
         // At the top decimal position up or down turns the sign on or off.
         if (press[3]) begin
            pend_neg_r <= 1'b0;
         end else if (press[2]) begin
            pend_neg_r <= 1'b1; // [RULE7]
         end
      end else if (state_r == editor_pkg::ST_EDIT && press[2]) begin
         pend_r[{pos_r, 2'b00} +: 4] <= (sel_digit == max_digit) ? 4'h0 : sel_digit + 4'h1; // [RULE5] [RULE15]
      end else if (state_r == editor_pkg::ST_EDIT && press[3]) begin
         pend_r[{pos_r, 2'b00} +: 4] <= (sel_digit == 4'h0) ? max_digit : sel_digit - 4'h1; // [RULE13] [RULE15]
      end
   end

   // Parameter store and applied copy, one entry per parameter number.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_param
         logic commit;
         assign commit = (state_r == editor_pkg::ST_EDIT) && (index_r == 3'(gi)) &&
            ((index_r >= `ED_PARAM_HEX_FIRST) ? ((press[0] && pos_r == `ED_HEX_TOP_POS)
            || press[1]) : press[0]);
         always_ff @(posedge MCLK or negedge RSTN) begin
            if (!RSTN) begin
               stored_r[gi] <= `ED_RESET_VALUE;
               stored_neg_r[gi] <= 1'b0;
            end else if (commit) begin
               stored_r[gi] <= pend_r; // [RULE6]
               stored_neg_r[gi] <= (gi < 4) && pend_neg_r; // [RULE7]
            end
         end
         // Power-up parameters keep their reset value; the rest follow the store.
         always_ff @(posedge MCLK or negedge RSTN) begin
            if (!RSTN) begin
               applied_r[gi] <= `ED_RESET_VALUE;
            end else if (!POWERUP_MASK[gi]) begin
               applied_r[gi] <= stored_r[gi]; // [RULE14]
            end
         end
      end
   endgenerate

   // Display outputs are registered so digits never glitch between screens.
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int d = 0; d < 5; d++) begin
            DIGIT_CODE[d] <= `ED_BLANK_CODE;
         end
         POINT_ON <= 5'h00;
         SEG_TOP_MARK <= 1'b0;
         SEG_BOTTOM_MARK <= 1'b0;
         PARAM_INDEX <= 3'h0;
         PARAM_APPLIED <= `ED_RESET_VALUE;
      end else begin
         PARAM_INDEX <= index_r;
         PARAM_APPLIED <= applied_r[index_r];
         POINT_ON <= 5'h00;
         SEG_TOP_MARK <= 1'b0;
         SEG_BOTTOM_MARK <= 1'b0;
         for (int d = 0; d < 5; d++) begin
            DIGIT_CODE[d] <= `ED_BLANK_CODE;
         end
         if (state_r == editor_pkg::ST_NUMBER) begin
            DIGIT_CODE[0] <= {2'b00, index_r};
         end else if (is_hex) begin
            // Digit 0 is rightmost; the word marks sit on the leftmost digit.
            for (int d = 0; d < 4; d++) begin
               DIGIT_CODE[d] <= {1'b0, view_val[(high_r ? 16 : 0) + 4 * d +: 4]};
               if (state_r == editor_pkg::ST_EDIT && blink && pos_r == 3'(high_r ? d + 4 : d)) begin
                  DIGIT_CODE[d] <= `ED_BLANK_CODE;
               end
            end
            SEG_BOTTOM_MARK <= !high_r; // [RULE10]
            SEG_TOP_MARK <= high_r; // [RULE11]
         end else if (!high_r) begin
            for (int d = 0; d < 5; d++) begin
               DIGIT_CODE[d] <= {1'b0, view_val[4 * d +: 4]}; // [RULE1]
               if (state_r == editor_pkg::ST_EDIT && blink && pos_r == 3'(d)) begin
                  DIGIT_CODE[d] <= `ED_BLANK_CODE; // [RULE3]
               end
            end
            POINT_ON <= view_neg ? 5'h19 : 5'h01; // [RULE1] [RULE8]
         end else begin
            DIGIT_CODE[0] <= {1'b0, view_val[20 +: 4]};
            DIGIT_CODE[1] <= view_neg ? `ED_MINUS_CODE : `ED_BLANK_CODE; // [RULE7]
            if (state_r == editor_pkg::ST_EDIT && blink) begin
               if (pos_r == `ED_DEC_LOW_DIGITS) begin
                  DIGIT_CODE[0] <= `ED_BLANK_CODE;
               end else if (pos_r == `ED_DEC_TOP_POS) begin
                  DIGIT_CODE[1] <= `ED_BLANK_CODE;
               end
            end
            POINT_ON <= 5'h02; // [RULE2]
         end
      end
   end
endmodule : param_editor

// ==== hdl/editor_map.svh ====
`ifndef EDITOR_MAP_SVH
`define EDITOR_MAP_SVH
`define ED_PARAM_COUNT 4'h8
`define ED_PARAM_HEX_FIRST 3'h4
`define ED_BLINK_MS 250
`define ED_CLK_KHZ 10000
`define ED_BLINK_CYCLES (`ED_BLINK_MS * `ED_CLK_KHZ)
`define ED_DEC_LOW_DIGITS 3'h5
`define ED_DEC_TOP_POS 3'h6
`define ED_HEX_TOP_POS 3'h7
`define ED_HEX_WORD_DIGITS 3'h4
`define ED_BLANK_CODE 5'h10
`define ED_MINUS_CODE 5'h11
`define ED_RESET_VALUE 32'h00000000
`endif

// ==== hdl/editor_pkg.sv ====
package editor_pkg;
   typedef enum logic [2:0] {
      ST_NUMBER = 3'b001,
      ST_VIEW   = 3'b010,
      ST_EDIT   = 3'b100
   } state_t;
   typedef logic [31:0] value_t;
endpackage : editor_pkg

// ==== hdl/key_pulse.sv ====
`timescale 1ns/10ps
// Turns each key level into a one-cycle press pulse on its rising edge.
module key_pulse (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic [3:0] KEY_LEVEL,
   output logic [3:0] KEY_PRESS
);
   logic [3:0] key_prev_r;

   // Previous level is held so a key held down gives only one press.
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         key_prev_r <= 4'h0;
      end else begin
         key_prev_r <= KEY_LEVEL;
      end
   end

   // Edge detect per key.
   assign KEY_PRESS = KEY_LEVEL & ~key_prev_r;
endmodule : key_pulse

// ==== hdl/blink_timer.sv ====
`timescale 1ns/10ps
`include "editor_map.svh"
// Divider that toggles the flash phase of the selected digit.
module blink_timer #(
   parameter int BLINK_CYCLES = `ED_BLINK_CYCLES
) (
   input wire logic MCLK,
   input wire logic RSTN,
   output logic BLINK_PHASE
);
   logic [21:0] count_r;
   logic phase_r;

   // Free-running count; a long half period keeps the flash readable.
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         count_r <= 22'h000000;
         phase_r <= 1'b0;
      end else if (count_r >= 22'(BLINK_CYCLES - 1)) begin
         count_r <= 22'h000000;
         phase_r <= ~phase_r;
      end else begin
         count_r <= count_r + 22'h000001;
      end
   end

   assign BLINK_PHASE = phase_r;
endmodule : blink_timer

// ==== tb/param_editor_checker.sv ====
`timescale 1ns/10ps
// Ties the editor's screen marks, index and values to the key presses that caused them, and range-checks the digit codes.
module param_editor_checker #(
   parameter logic [7:0] POWERUP_MASK = 8'h01
) (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic KEY_SET,
   input wire logic KEY_MODE,
   input wire logic KEY_UP,
   input wire logic KEY_DOWN,
   input wire logic [2:0] PARAM_INDEX,
   input wire logic [31:0] PARAM_APPLIED,
   input wire logic [4:0] DIGIT_CODE [5],
   input wire logic [4:0] POINT_ON,
   input wire logic SEG_TOP_MARK,
   input wire logic SEG_BOTTOM_MARK
);
   logic [3:0] keys_r;
   logic any_rise;
   logic dec_ok;
   logic code_ok;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   // A held key must not count twice, so only the rising edge is a press.
   assign any_rise = |({KEY_DOWN, KEY_UP, KEY_MODE, KEY_SET} & ~keys_r);
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN)
         keys_r <= 4'h0;
      else
         keys_r <= {KEY_DOWN, KEY_UP, KEY_MODE, KEY_SET};
   end
   // Digit codes ten to fifteen are legal only on hex screens, where no point is lit.
   always_comb begin
      dec_ok = 1'b1;
      code_ok = 1'b1;
      for (int i = 0; i < 5; i++) begin
         if (DIGIT_CODE[i] > 5'h09 && DIGIT_CODE[i] < 5'h10)
            dec_ok = 1'b0;
         if (DIGIT_CODE[i] > 5'h11)
            code_ok = 1'b0;
      end
   end
   sequence s_idle;
      !any_rise [*4];
   endsequence
   property p_mark_excl; !(SEG_TOP_MARK && SEG_BOTTOM_MARK); endproperty
   a_mark_excl: assert property (p_mark_excl) else $error("both word marks lit");
   property p_mark_nopt; (SEG_TOP_MARK || SEG_BOTTOM_MARK) |-> POINT_ON == 5'h00; endproperty
   a_mark_nopt: assert property (p_mark_nopt) else $error("point lit on hex word");
   property p_pt_set; POINT_ON inside {5'h00, 5'h01, 5'h02, 5'h19}; endproperty
   a_pt_set: assert property (p_pt_set) else $error("odd point pattern");
   property p_code_range; code_ok; endproperty
   a_code_range: assert property (p_code_range) else $error("digit code out of range");
   property p_dec_digits; POINT_ON != 5'h00 |-> dec_ok; endproperty
   a_dec_digits: assert property (p_dec_digits) else $error("hex digit on decimal");
   property p_freeze;
      POWERUP_MASK[PARAM_INDEX] && $stable(PARAM_INDEX) |-> $stable(PARAM_APPLIED);
   endproperty
   a_freeze: assert property (p_freeze) else $error("power-up value moved");
   property p_pt_latency;
      $changed(POINT_ON) || $changed(SEG_TOP_MARK) || $changed(SEG_BOTTOM_MARK)
         |-> $past(any_rise, 2);
   endproperty
   a_pt_latency: assert property (p_pt_latency) else $error("mark moved off press");
   property p_idx_cause; $changed(PARAM_INDEX) |-> $past(any_rise) || $past(any_rise, 2); endproperty
   a_idx_cause: assert property (p_idx_cause) else $error("index moved unasked");
   property p_idle_hold; s_idle |-> $stable(PARAM_APPLIED) && $stable(PARAM_INDEX); endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("value moved when idle");
endmodule : param_editor_checker

bind param_editor param_editor_checker #(.POWERUP_MASK(POWERUP_MASK)) u_param_editor_checker (
   .MCLK(MCLK), .RSTN(RSTN), .KEY_SET(KEY_SET), .KEY_MODE(KEY_MODE), .KEY_UP(KEY_UP),
   .KEY_DOWN(KEY_DOWN), .PARAM_INDEX(PARAM_INDEX), .PARAM_APPLIED(PARAM_APPLIED),
   .DIGIT_CODE(DIGIT_CODE), .POINT_ON(POINT_ON), .SEG_TOP_MARK(SEG_TOP_MARK),
   .SEG_BOTTOM_MARK(SEG_BOTTOM_MARK));

// ==== tb/keypad_operator.sv ====
`timescale 1ns/10ps
// Operator at the panel: holds a key two cycles, then lets go for a chosen gap.
module keypad_operator (
   input wire logic clk,
   output logic [3:0] keys
);
   initial keys = 4'h0;
   // A gap of at least two cycles keeps each press a separate rising edge.
   task automatic press(input int k, input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         #1 keys[k] = 1'b1;
         repeat (2) @(posedge clk);
         #1 keys[k] = 1'b0;
         repeat (gap) @(posedge clk);
      end
   endtask : press
endmodule : keypad_operator

// ==== tb/param_editor_test.sv ====
`timescale 1ns/10ps
// Walks an operator through decimal, signed and hex edits on the front panel.
module param_editor_test;
   localparam int K_SET = 0;
   localparam int K_MODE = 1;
   localparam int K_UP = 2;
   localparam int K_DOWN = 3;
   logic mclk;
   logic rstn;
   logic [3:0] keys;
   logic [2:0] param_index;
   logic [31:0] param_applied;
   logic [4:0] digit_code [5];
   logic [4:0] point_on;
   logic seg_top_mark;
   logic seg_bottom_mark;
   int n_mismatch = 0;
   int comparisons = 0;
   // A short blink keeps flashing digits observable within a dozen cycles.
   param_editor #(.BLINK_CYCLES(4), .POWERUP_MASK(8'h01)) u_param_editor (
      .MCLK(mclk), .RSTN(rstn), .KEY_SET(keys[0]), .KEY_MODE(keys[1]), .KEY_UP(keys[2]),
      .KEY_DOWN(keys[3]), .PARAM_INDEX(param_index), .PARAM_APPLIED(param_applied),
      .DIGIT_CODE(digit_code), .POINT_ON(point_on), .SEG_TOP_MARK(seg_top_mark),
      .SEG_BOTTOM_MARK(seg_bottom_mark));
   keypad_operator u_keypad_operator (.clk(mclk), .keys(keys));
   task automatic chk5(input string what, input logic [4:0] exp, input logic [4:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk5
   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk32
   // Returning just after the edge keeps later samples clear of the register updates.
   task automatic hit(input int k, input int n);
      u_keypad_operator.press(k, n, 2);
      #1;
   endtask : hit
   // The selected digit blanks for half the blink, so keep the last lit value.
   task automatic flash(input int i, input logic [4:0] exp, input string what);
      logic [4:0] v;
      v = 5'h10;
      repeat (12) begin
         @(posedge mclk);
         #2 if (digit_code[i] !== 5'h10) v = digit_code[i];
      end
      chk5(what, exp, v);
   endtask : flash
   task automatic t_screens();
      chk5("number screen", 5'h00, digit_code[0]);
      hit(K_SET, 1);
      chk5("low point", 5'h01, point_on);
      hit(K_MODE, 1);
      chk5("high point", 5'h02, point_on);
      hit(K_MODE, 1);
      chk5("back low", 5'h01, point_on);
   endtask : t_screens
   task automatic t_freeze();
      hit(K_SET, 1);
      hit(K_UP, 1);
      flash(0, 5'h01, "edit digit");
      hit(K_SET, 1);
      chk32("frozen", 32'h00000000, param_applied);
   endtask : t_freeze
   task automatic t_digits();
      hit(K_UP, 1);
      chk32("index", 32'h00000001, {29'h0, param_index});
      chk5("next low", 5'h01, point_on);
      hit(K_SET, 1);
      hit(K_DOWN, 1);
      flash(0, 5'h09, "wrap down");
      hit(K_UP, 2);
      flash(0, 5'h01, "wrap up");
      chk5("no carry", 5'h00, digit_code[1]);
      hit(K_MODE, 5);
      hit(K_UP, 2);
      hit(K_SET, 1);
      chk32("dec commit", 32'h00200001, param_applied);
   endtask : t_digits
   task automatic t_sign();
      hit(K_UP, 1);
      hit(K_MODE, 1);
      hit(K_SET, 1);
      hit(K_MODE, 1);
      flash(1, 5'h11, "minus");
      hit(K_SET, 1);
      hit(K_MODE, 1);
      chk5("neg points", 5'h19, point_on);
   endtask : t_sign
   task automatic t_hex();
      u_keypad_operator.press(K_UP, 2, 6);
      #1;
      chk5("low word", 5'h01, {4'h0, seg_bottom_mark});
      hit(K_MODE, 1);
      chk5("high word", 5'h01, {4'h0, seg_top_mark});
      hit(K_MODE, 1);
      hit(K_SET, 5);
      hit(K_DOWN, 2);
      flash(0, 5'h0e, "hex digit");
      hit(K_MODE, 1);
      chk32("hex commit", 32'h000e0000, param_applied);
   endtask : t_hex
   task automatic conclude();
      if (n_mismatch == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Each step assumes the screen the previous one left, so the order matters.
   initial begin
      rstn = 1'b0;
      repeat (12) @(posedge mclk);
      #1 rstn = 1'b1;
      repeat (2) @(posedge mclk);
      t_screens();
      t_freeze();
      t_digits();
      t_sign();
      t_hex();
      conclude();
   end
   // The walk needs well under a thousand cycles; this only cuts a hang short.
   initial begin
      repeat (5000) @(posedge mclk);
      n_mismatch++;
      conclude();
   end
endmodule : param_editor_test
